// [verilog/sld_pkg.sv]
// Purpose : Shared constants for the serial segment latch link.
// Assumes : Reference clock of 100 MHz on both ends.
// Notes   : Link clock timing is derived from the fastest allowed link rate.
package sld_pkg;

  // Frame layout
  localparam int FRAME_BITS = 36;
  localparam int SEG_BITS   = 35;
  localparam int CNT_W      = 6;

  // Position of the start bit inside the shift chain
  localparam int START_POS  = FRAME_BITS - 1;

  // Segment held low in the enable variant
  localparam int EN_SEG     = SEG_BITS - 1;

  // Timing
  localparam int REF_CLK_KHZ   = 100000;
  localparam int LINK_FMAX_KHZ = 500;
  // Shortest half period of the link clock, in ns
  localparam int LINK_HALF_NS  = 1000000 / (2 * LINK_FMAX_KHZ);
  // Least time rounds up to whole reference cycles
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * (REF_CLK_KHZ / 1000) + 999) / 1000;
  localparam int DIV_W         = $clog2(LINK_HALF_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);

  // Source sequencer states
  typedef enum logic [1:0] {
    SLD_IDLE = 2'b00,
    SLD_LOW  = 2'b01,
    SLD_HIGH = 2'b10
  } sld_src_st_type;

endpackage : sld_pkg

// [verilog/sld_link_if.sv]
// Purpose : Three-wire serial link between data source and segment latch.
// Assumes : All wires are driven by the source only.
// Notes   : data_en is only looked at by the enable variant of the latch.
`timescale 1ns/10ps
interface sld_link_if;

  logic ser_clk;
  logic ser_data;
  logic data_en;

  modport dev (
    input ser_clk,
    input ser_data,
    input data_en
  );

  modport src (
    output ser_clk,
    output ser_data,
    output data_en
  );

endinterface : sld_link_if

// [verilog/sld_dev.sv]
// Purpose : Segment latch end: receives 36-bit frames, drives 35 segments.
// Assumes : Link pins are asynchronous to ref_clk and much slower than it.
// Notes   : Link edges are found by sampling; rst_b stands for power-on reset.
// Behaviour
// - Only serial data and shift clock carry frames
// - Frame end found internally, no load strobe
// - Source sends start one then 35 bits
// - 36th clock high copies chain into latches
// - Following clock low clears the shift chain
// - Clear zeroes every chain stage, first included
// - Source always sends complete 36-clock frames
// - Only differing segment bits change their output
// - Power-up reset clears chain and latches
// - Start bit after reset resumes reception
// - First data bit drives first segment
// - Enable variant loses the 35th segment output
// - Link clock no faster than 0.5 MHz
`timescale 1ns/10ps
module sld_dev #(
  parameter bit HAS_DATA_EN = 1'b0
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  sld_link_if.dev                        link,
  output logic [sld_pkg::SEG_BITS-1:0]   seg_on_q,
  output logic                           load_pulse_q
);

  typedef struct packed {
    logic [2:0]                     clk_s;
    logic [2:0]                     dat_s;
    logic [2:0]                     en_s;
    logic                           clk_f;
    logic                           dat_f;
    logic                           en_f;
    logic [sld_pkg::FRAME_BITS-1:0] chain;
    logic                           clr_pend;
    logic [sld_pkg::SEG_BITS-1:0]   seg;
    logic                           load;
  } sld_dev_state_type;

  sld_dev_state_type q;
  sld_dev_state_type n;

  logic                           clk_rise;
  logic                           clk_fall;
  logic                           shift_ok;
  logic [sld_pkg::FRAME_BITS-1:0] shifted;
  logic [sld_pkg::SEG_BITS-1:0]   new_seg;
  logic [sld_pkg::SEG_BITS-1:0]   diff;

  // A level counts once the second and third flops agree
  function automatic logic agree(
    input logic s2,
    input logic s3,
    input logic prev
  );
    logic r;
    r = prev;
    if (s2 == s3) begin
      r = s2;
    end
    return r;
  endfunction : agree

  always_comb begin
    n        = q;
    clk_rise = 1'b0;
    clk_fall = 1'b0;
    shift_ok = 1'b0;
    shifted  = '0;
    new_seg  = '0;
    diff     = '0;
    n.load   = 1'b0;

    n.clk_s = {q.clk_s[1:0], link.ser_clk};
    n.dat_s = {q.dat_s[1:0], link.ser_data};
    n.en_s  = {q.en_s[1:0], link.data_en};

    n.clk_f = agree(q.clk_s[1], q.clk_s[2], q.clk_f);
    n.dat_f = agree(q.dat_s[1], q.dat_s[2], q.dat_f);
    n.en_f  = agree(q.en_s[1], q.en_s[2], q.en_f);

    clk_rise = n.clk_f & ~q.clk_f;
    clk_fall = ~n.clk_f & q.clk_f;

    if (HAS_DATA_EN) begin
      shift_ok = clk_rise & n.en_f;
    end else begin
      shift_ok = clk_rise;
    end

    if (shift_ok && !q.clr_pend) begin
      shifted = {q.chain[sld_pkg::FRAME_BITS-2:0], n.dat_f};
      n.chain = shifted;
      if (shifted[sld_pkg::START_POS]) begin
        for (int i = 0; i < sld_pkg::SEG_BITS; i++) begin
          new_seg[i] = shifted[sld_pkg::START_POS-1-i];
        end
        if (HAS_DATA_EN) begin
          new_seg[sld_pkg::EN_SEG] = 1'b0;
        end
        diff       = q.seg ^ new_seg;
        n.seg      = q.seg ^ diff;
        n.load     = 1'b1;
        n.clr_pend = 1'b1;
      end
    end

    if (clk_fall && q.clr_pend) begin
      n.chain    = '0;
      n.clr_pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign seg_on_q     = q.seg;
  assign load_pulse_q = q.load;

endmodule : sld_dev

// [verilog/sld_src.sv]
// Purpose : Data source end: sends one 36-bit frame per accepted request.
// Assumes : Link clock made here by dividing ref_clk; idles low.
// Notes   : data_en is high for the whole frame and low in idle.
`timescale 1ns/10ps
module sld_src (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  sld_link_if.src                        link,
  input  wire logic                      frame_valid,
  input  wire logic [sld_pkg::SEG_BITS-1:0] frame_data,
  output logic                           frame_ready_q
);

  typedef struct packed {
    sld_pkg::sld_src_st_type        st;
    logic [sld_pkg::DIV_W-1:0]      div;
    logic [sld_pkg::CNT_W-1:0]      cnt;
    logic [sld_pkg::FRAME_BITS-1:0] shreg;
    logic                           clk;
    logic                           dat;
    logic                           en;
    logic                           ready;
  } sld_src_state_type;

  sld_src_state_type              q;
  sld_src_state_type              n;
  logic                           tick;
  logic [sld_pkg::FRAME_BITS-1:0] frame;

  always_comb begin
    n    = q;
    tick = (q.div == sld_pkg::DIV_LAST);
    // start bit then segment one first
    frame = '0;
    frame[sld_pkg::START_POS] = 1'b1;
    for (int i = 0; i < sld_pkg::SEG_BITS; i++) begin
      frame[sld_pkg::START_POS-1-i] = frame_data[i];
    end

    case (q.st)
      sld_pkg::SLD_IDLE: begin
        n.ready = 1'b1;
        n.div   = '0;
        if (frame_valid && q.ready) begin
          n.shreg = frame;
          n.dat   = frame[sld_pkg::START_POS];
          n.en    = 1'b1;
          n.cnt   = '0;
          n.ready = 1'b0;
          n.st    = sld_pkg::SLD_LOW;
        end
      end
      sld_pkg::SLD_LOW: begin
        n.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
          n.clk = 1'b1;
          n.st  = sld_pkg::SLD_HIGH;
        end
      end
      sld_pkg::SLD_HIGH: begin
        n.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
          n.clk = 1'b0;
          n.cnt = q.cnt + 1'b1;
          if (q.cnt == sld_pkg::CNT_LAST) begin
            n.dat   = 1'b0;
            n.en    = 1'b0;
            n.ready = 1'b1;
            n.st    = sld_pkg::SLD_IDLE;
          end else begin
            // data moves with the falling edge
            n.shreg = {q.shreg[sld_pkg::FRAME_BITS-2:0], 1'b0};
            n.dat   = q.shreg[sld_pkg::START_POS-1];
            n.st    = sld_pkg::SLD_LOW;
          end
        end
      end
      default: begin
        n.st = sld_pkg::SLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign link.ser_clk  = q.clk;
  assign link.ser_data = q.dat;
  assign link.data_en  = q.en;
  assign frame_ready_q = q.ready;

endmodule : sld_src

// [dv/sld_properties.sv]
// Purpose : Link and latch timing properties for the serial segment latch.
// Assumes : One ref_clk domain, rst_b active low.
// Notes   : Watches the link wires and the user sides of both ends.
`timescale 1ns/10ps
module sld_properties (
  input wire logic                         ref_clk,
  input wire logic                         rst_b,
  input wire logic                         ser_clk,
  input wire logic                         ser_data,
  input wire logic                         data_en,
  input wire logic                         frame_valid,
  input wire logic                         frame_ready_q,
  input wire logic [sld_pkg::SEG_BITS-1:0] seg_on_q,
  input wire logic                         load_pulse_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] hi_cnt_q;
  // Counts reference cycles of the current link clock high phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt_q <= 8'h00;
    end else if (ser_clk) begin
      hi_cnt_q <= hi_cnt_q + 8'h01;
    end else begin
      hi_cnt_q <= 8'h00;
    end
  end
  property p_clk_long; $fell(ser_clk) |-> (hi_cnt_q >= 8'(sld_pkg::LINK_HALF_CYC)); endproperty
  a_clk_long: assert property (p_clk_long) else $error("link clock high phase too short");
  property p_data_low; $changed(ser_data) |-> !ser_clk; endproperty
  a_data_low: assert property (p_data_low) else $error("data moved while clock high");
  property p_clk_half; $rose(ser_clk) |=> $stable(ser_clk) [*8]; endproperty
  a_clk_half: assert property (p_clk_half) else $error("link clock high too short");
  property p_pulse_one; load_pulse_q |=> !load_pulse_q; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("load pulse too long");
  property p_load_high; load_pulse_q |-> ser_clk; endproperty
  a_load_high: assert property (p_load_high) else $error("load outside clock high");
  property p_seg_change; $changed(seg_on_q) |-> load_pulse_q; endproperty
  a_seg_change: assert property (p_seg_change) else $error("segments moved without load");
  property p_en_rise; $rose(ser_clk) |-> data_en; endproperty
  a_en_rise: assert property (p_en_rise) else $error("clock rise with enable low");
  property p_idle_low; frame_ready_q |-> !ser_clk && !data_en; endproperty
  a_idle_low: assert property (p_idle_low) else $error("link not idle when ready");
  property p_start; $rose(data_en) |-> ser_data; endproperty
  a_start: assert property (p_start) else $error("frame lacks start one");
  property p_take; frame_valid && frame_ready_q |=> !frame_ready_q; endproperty
  a_take: assert property (p_take) else $error("request not taken");
endmodule : sld_properties

// [dv/tb_serial_led_segment_latch.sv]
// Purpose : Sends frames source to latch and checks the latched segments.
// Assumes : Design ends face each other; a second latch is the enable variant.
// Notes   : Each frame takes about 7200 reference cycles.
`timescale 1ns/10ps
module tb_serial_led_segment_latch;
  logic                         ref_clk = 1'b0;
  logic                         rst_b = 1'b0;
  logic                         frame_valid = 1'b0;
  logic [sld_pkg::SEG_BITS-1:0] frame_data = '0;
  logic                         frame_ready_q;
  logic [sld_pkg::SEG_BITS-1:0] seg_on_q;
  logic [sld_pkg::SEG_BITS-1:0] seg_en_q;
  logic                         load_pulse_q;
  int                           bad_count = 0;
  int                           n_tests = 0;
  sld_link_if link ();
  sld_src sld_src_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link), .frame_valid(frame_valid),
    .frame_data(frame_data), .frame_ready_q(frame_ready_q));
  sld_dev sld_dev_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link), .seg_on_q(seg_on_q),
    .load_pulse_q(load_pulse_q));
  sld_dev #(.HAS_DATA_EN(1'b1)) sld_dev_en_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link),
    .seg_on_q(seg_en_q), .load_pulse_q());
  sld_properties sld_properties_i (.ref_clk(ref_clk), .rst_b(rst_b), .ser_clk(link.ser_clk),
    .ser_data(link.ser_data), .data_en(link.data_en), .frame_valid(frame_valid),
    .frame_ready_q(frame_ready_q), .seg_on_q(seg_on_q), .load_pulse_q(load_pulse_q));
  always #5 ref_clk = ~ref_clk;
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string what, input logic [34:0] exp, input logic [34:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // Request one frame, wait for the load, check both latches
  task automatic send(input logic [34:0] d);
    int k;
    frame_data = d;
    frame_valid = 1'b1;
    for (k = 0; k < 9000 && frame_ready_q !== 1'b1; k++) @(posedge ref_clk) #1;
    // A source that never becomes ready counts as a mismatch
    if (k >= 9000) bad_count++;
    @(posedge ref_clk) #1;
    frame_valid = 1'b0;
    for (k = 0; k < 9000 && load_pulse_q !== 1'b1; k++) @(posedge ref_clk) #1;
    // A load that never comes counts as a mismatch
    if (k >= 9000) bad_count++;
    cmp("seg", d, seg_on_q);
    cmp("seg_en", {1'b0, d[33:0]}, seg_en_q);
  endtask : send
  task automatic t_power_on();
    cmp("seg_rst", '0, seg_on_q);
    send(35'h0_0000_0001);
  endtask : t_power_on
  task automatic t_back_to_back();
    send(35'h7_ffff_ffff);
    send(35'h5_5555_5555);
    send(35'h2_aaaa_aaaa);
    send(35'h4_0000_0000);
  endtask : t_back_to_back
  task automatic t_mid_reset();
    frame_data = 35'h3_1234_5678;
    frame_valid = 1'b1;
    repeat (2000) @(posedge ref_clk);
    #1 rst_b = 1'b0;
    frame_valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp("seg_mid_rst", '0, seg_on_q);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    send(35'h1_0f0f_0f0f);
  endtask : t_mid_reset
  initial begin
    #(80_000 * 10);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge ref_clk) #1;
    t_power_on();
    t_back_to_back();
    t_mid_reset();
    report_and_stop();
  end
endmodule : tb_serial_led_segment_latch
